/* File: design/dcf_channel.sv */
// Channel descriptor registers with AXI4-Lite slave and address stepping
`timescale 1ns/10ps
`include "dcf_defines.svh"
module dcf_channel
(
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Synchronous reset, active low
    input  wire logic [11:0] s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Byte enables
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [11:0] s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic        item_done,     // Transfer engine moved one item
    output dcf_pkg::dcf_ctrl_t ctrl_fields, // Decoded control fields
    output dcf_pkg::dcf_addr_t item_addr,   // Addresses of the current item
    output logic             config_error   // Reserved width present at the last start
);
    logic [31:0] src_end_q;   // Source end pointer
    logic [31:0] src_end_d;
    logic [31:0] dst_end_q;   // Destination end pointer
    logic [31:0] dst_end_d;
    logic [31:0] ctrl_q;      // Channel control word
    logic [31:0] ctrl_d;
    logic [7:0]  items_q;     // Item count minus one, written with start
    logic [7:0]  items_d;
    logic [7:0]  left_q;      // Items still to move minus one
    logic [7:0]  left_d;
    logic        busy_q;      // Transfer running
    logic        busy_d;
    logic        err_q;       // Configuration error sticky flag
    logic        err_d;
    logic        aw_got_q;    // Write address held
    logic        aw_got_d;
    logic        w_got_q;     // Write data held
    logic        w_got_d;
    logic [11:0] awaddr_q;
    logic [11:0] awaddr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [3:0]  wstrb_q;
    logic [3:0]  wstrb_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic        do_write;    // Both halves of a write present
    logic        start;       // Software started a transfer
    logic        width_bad;   // Reserved width code present
    logic        advance;     // Step addresses this cycle
    logic [31:0] merged;      // Write data merged under byte enables

    // Merge write data into the old value per byte lane
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        lanes = r;
    endfunction

    assign ctrl_fields   = dcf_pkg::dcf_ctrl_t'(ctrl_q[31:18]);
    // Reserved width in either field refuses the transfer
    assign width_bad     = (ctrl_q[`DCF_DST_WID_HI:`DCF_DST_WID_LO] == `DCF_CODE_NONE)
                        || (ctrl_q[`DCF_SRC_WID_HI:`DCF_SRC_WID_LO] == `DCF_CODE_NONE); // see R14, see R6, see R11
    assign do_write      = aw_got_q && w_got_q && !bvalid_q;
    assign start         = do_write && (awaddr_q == `DCF_OFS_START) && wstrb_q[0];
    assign advance       = busy_q && item_done;
    assign s_axi_awready = !aw_got_q;
    assign s_axi_wready  = !w_got_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign config_error  = err_q;

    // Write channel capture, register writes and response
    always_comb
    begin
        aw_got_d  = aw_got_q;
        w_got_d   = w_got_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        src_end_d = src_end_q;
        dst_end_d = dst_end_q;
        ctrl_d    = ctrl_q;
        items_d   = items_q;
        merged    = 32'h0000_0000;
        if (s_axi_awvalid && !aw_got_q)
        begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_q)
        begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (do_write)
        begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = `DCF_RESP_OKAY;
            unique case (awaddr_q)
                `DCF_OFS_SRC_END:  src_end_d = lanes(src_end_q, wdata_q, wstrb_q);
                `DCF_OFS_DST_END:  dst_end_d = lanes(dst_end_q, wdata_q, wstrb_q);
                `DCF_OFS_CTRL:
                begin
                    // Reserved bits are stored as written so read-back preserves them
                    merged = lanes(ctrl_q, wdata_q, wstrb_q);
                    ctrl_d = merged;
                end
                `DCF_OFS_START:    items_d = wdata_q[7:0];
                `DCF_OFS_STATUS, `DCF_OFS_DST_ADDR, `DCF_OFS_SRC_ADDR: ;
                default:           bresp_d = `DCF_RESP_SLVERR;
            endcase
        end
    end

    // Read channel: registered data, unmapped answers SLVERR
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = `DCF_RESP_OKAY;
            unique case (s_axi_araddr)
                `DCF_OFS_SRC_END:  rdata_d = src_end_q;
                `DCF_OFS_DST_END:  rdata_d = dst_end_q;
                `DCF_OFS_CTRL:     rdata_d = ctrl_q;
                `DCF_OFS_START:    rdata_d = {24'h000000, items_q};
                `DCF_OFS_STATUS:   rdata_d = {14'h0000, left_q, 8'h00, err_q, busy_q};
                `DCF_OFS_DST_ADDR: rdata_d = item_addr.dst;
                `DCF_OFS_SRC_ADDR: rdata_d = item_addr.src;
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `DCF_RESP_SLVERR;
                end
            endcase
        end
    end

    // Transfer progress and configuration error
    always_comb
    begin
        busy_d = busy_q;
        left_d = left_q;
        err_d  = err_q;
        if (start)
        begin
            if (width_bad)
            begin
                err_d  = 1'b1;                // see R14
                busy_d = 1'b0;
            end
            else
            begin
                err_d  = 1'b0;
                busy_d = 1'b1;
                left_d = wdata_q[7:0];
            end
        end
        else if (advance)
        begin
            if (left_q == 8'h00)
                busy_d = 1'b0;                // Last item sits on the end pointer
            else
                left_d = left_q - 8'h01;
        end
    end

    // State registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_end_q <= `DCF_RESET_WORD;
            dst_end_q <= `DCF_RESET_WORD;
            ctrl_q    <= `DCF_RESET_WORD;
            items_q   <= 8'h00;
            left_q    <= 8'h00;
            busy_q    <= 1'b0;
            err_q     <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'h0;
        end
        else
        begin
            src_end_q <= src_end_d;
            dst_end_q <= dst_end_d;
            ctrl_q    <= ctrl_d;
            items_q   <= items_d;
            left_q    <= left_d;
            busy_q    <= busy_d;
            err_q     <= err_d;
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // Address stepping from the end pointers
    dcf_addr_gen u_addr
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (start && !width_bad),
        .advance (advance),
        .items   (wdata_q[7:0]),
        .src_end (src_end_q),
        .dst_end (dst_end_q),
        .ctrl    (ctrl_fields),
        .addr    (item_addr)
    );
endmodule

/* File: design/dcf_defines.svh */
// Offsets, field positions, reset values and encodings of the channel descriptor block
// Overview of operation
// R1 - Destination end pointer is inclusive last address
// R2 - Software loads fixed target when no advance
// R3 - Destination step codes byte, half, word
// R4 - Step code three keeps destination fixed
// R5 - Software keeps destination step above width
// R6 - Destination width decode, code three reserved
// R7 - Software sets equal source and destination widths
// R8 - Source step codes byte, half, word
// R9 - Step code three holds source fixed
// R10 - Software keeps source step above width
// R11 - Source width decode, code three reserved
// R12 - Software preserves reserved bits 23:18
// R13 - Source end pointer inclusive or fixed
// R14 - Reserved width flagged as configuration error
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH
`define DCF_OFS_SRC_END    12'h000
`define DCF_OFS_DST_END    12'h004
`define DCF_OFS_CTRL       12'h008
`define DCF_OFS_START      12'h00C
`define DCF_OFS_STATUS     12'h010
`define DCF_OFS_DST_ADDR   12'h014
`define DCF_OFS_SRC_ADDR   12'h018
`define DCF_DST_STEP_HI    31
`define DCF_DST_STEP_LO    30
`define DCF_DST_WID_HI     29
`define DCF_DST_WID_LO     28
`define DCF_SRC_STEP_HI    27
`define DCF_SRC_STEP_LO    26
`define DCF_SRC_WID_HI     25
`define DCF_SRC_WID_LO     24
`define DCF_RSV_HI         23
`define DCF_RSV_LO         18
`define DCF_CODE_NONE      2'h3
`define DCF_RESET_WORD     32'h0000_0000
`define DCF_RESP_OKAY      2'h0
`define DCF_RESP_SLVERR    2'h2
`endif

/* File: design/dcf_pkg.sv */
// Types shared by the channel descriptor block
package dcf_pkg;
    // Unit coded in an address step or item width field
    typedef enum logic [1:0] {DCF_BYTE, DCF_HALF, DCF_WORD, DCF_CODE3} dcf_unit_t;
    // Decoded channel control word
    typedef struct packed {
        dcf_unit_t dst_step;
        dcf_unit_t dst_width;
        dcf_unit_t src_step;
        dcf_unit_t src_width;
        logic [5:0] rsv;
    } dcf_ctrl_t;
    // Address pair produced for one item
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
    } dcf_addr_t;
endpackage

/* File: design/dcf_addr_gen.sv */
// Per-item address generator counting up to inclusive end pointers
`timescale 1ns/10ps
`include "dcf_defines.svh"
module dcf_addr_gen
(
    input  wire logic             aclk,      // System clock
    input  wire logic             aresetn,   // Synchronous reset, active low
    input  wire logic             load,      // Start a new transfer
    input  wire logic             advance,   // One item moved
    input  wire logic [7:0]       items,     // Item count minus one
    input  wire logic [31:0]      src_end,   // Inclusive last source address
    input  wire logic [31:0]      dst_end,   // Inclusive last destination address
    input  wire dcf_pkg::dcf_ctrl_t ctrl,    // Decoded control fields
    output dcf_pkg::dcf_addr_t    addr       // Current item addresses
);
    logic [31:0] src_q;      // Current source address
    logic [31:0] src_d;      // Next source address
    logic [31:0] dst_q;      // Current destination address
    logic [31:0] dst_d;      // Next destination address

    // Offset that places the first item so the last one lands on the end pointer
    function automatic logic [31:0] span(input dcf_pkg::dcf_unit_t s, input logic [7:0] n);
        logic [31:0] w;
        w = {24'h000000, n};
        unique case (s)
            dcf_pkg::DCF_BYTE:  span = w;
            dcf_pkg::DCF_HALF:  span = {w[30:0], 1'b0};
            dcf_pkg::DCF_WORD:  span = {w[29:0], 2'b00};
            dcf_pkg::DCF_CODE3: span = 32'h0000_0000;
        endcase
    endfunction

    // Increment size for one item
    function automatic logic [31:0] step(input dcf_pkg::dcf_unit_t s);
        unique case (s)
            dcf_pkg::DCF_BYTE:  step = 32'h0000_0001;
            dcf_pkg::DCF_HALF:  step = 32'h0000_0002;
            dcf_pkg::DCF_WORD:  step = 32'h0000_0004;
            dcf_pkg::DCF_CODE3: step = 32'h0000_0000;
        endcase
    endfunction

    // Next address computation
    always_comb
    begin
        src_d = src_q;
        dst_d = dst_q;
        if (load)
        begin
            src_d = src_end - span(ctrl.src_step, items);   // see R13, see R9
            dst_d = dst_end - span(ctrl.dst_step, items);   // see R1, see R4
        end
        else if (advance)
        begin
            src_d = src_q + step(ctrl.src_step);            // see R8, see R9
            dst_d = dst_q + step(ctrl.dst_step);            // see R3, see R4
        end
    end

    // Address registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_q <= `DCF_RESET_WORD;
            dst_q <= `DCF_RESET_WORD;
        end
        else
        begin
            src_q <= src_d;
            dst_q <= dst_d;
        end
    end

    assign addr.src = src_q;
    assign addr.dst = dst_q;
endmodule

/* File: testbench/dcf_channel_props.sv */
// Port checks for the channel descriptor block
`timescale 1ns/10ps
module dcf_channel_props
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               item_done,
    input wire dcf_pkg::dcf_ctrl_t ctrl_fields,
    input wire dcf_pkg::dcf_addr_t item_addr,
    input wire logic               config_error
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Step size of a code, zero for no advance
    function automatic logic [31:0] unit(input dcf_pkg::dcf_unit_t c);
        unit = (c == dcf_pkg::DCF_CODE3) ? 32'h0 : (32'h1 << c);
    endfunction
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    dst_step_a: assert property (item_done && ctrl_fields.dst_step != dcf_pkg::DCF_CODE3 |=>
        item_addr.dst == $past(item_addr.dst) + unit($past(ctrl_fields.dst_step)))
        else $error("destination step wrong");
    src_step_a: assert property (item_done && ctrl_fields.src_step != dcf_pkg::DCF_CODE3 |=>
        item_addr.src == $past(item_addr.src) + unit($past(ctrl_fields.src_step)))
        else $error("source step wrong");
    dst_fixed_a: assert property (item_done && ctrl_fields.dst_step == dcf_pkg::DCF_CODE3 |=>
        $stable(item_addr.dst)) else $error("destination moved");
    src_fixed_a: assert property (item_done && ctrl_fields.src_step == dcf_pkg::DCF_CODE3 |=>
        $stable(item_addr.src)) else $error("source moved");
    cfg_flag_a: assert property ($rose(config_error) |->
        ctrl_fields.dst_width == dcf_pkg::DCF_CODE3 || ctrl_fields.src_width == dcf_pkg::DCF_CODE3)
        else $error("error flag without reserved width");
    // Main scenarios
    cover property (s_axi_arvalid && s_axi_arready);
    cover property (item_done && ctrl_fields.dst_step == dcf_pkg::DCF_CODE3);
    cover property ($rose(config_error));
endmodule

/* File: testbench/dcf_engine_model.sv */
// Transfer engine model pulsing item_done with a stall gap
`timescale 1ns/10ps
module dcf_engine_model
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       go,
    input wire logic [7:0] count,
    input wire logic [3:0] gap,
    output logic           item_done,
    output logic           busy
);
    logic [8:0] left_q; // Items still to move
    logic [3:0] wait_q; // Stall cycles before next item
    assign busy = (left_q != 9'h0);
    // Emits count plus one pulses, stalling gap cycles before each
    always_ff @(posedge aclk)
    begin
        item_done <= 1'b0;
        if (!aresetn)
            left_q <= 9'h0;
        else if (go)
        begin
            left_q <= {1'b0, count} + 9'h1;
            wait_q <= gap;
        end
        else if (busy && wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
        else if (busy)
        begin
            item_done <= 1'b1;
            left_q    <= left_q - 9'h1;
            wait_q    <= gap;
        end
    end
endmodule

/* File: testbench/dcf_channel_test.sv */
// Self-checking bench for the channel descriptor block
`timescale 1ns/10ps
`include "dcf_defines.svh"
module dcf_channel_test;
    logic               aclk, aresetn, item_done, config_error, eng_go, eng_busy;
    logic [11:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]         s_axi_wstrb, eng_gap;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic               s_axi_rvalid, s_axi_rready;
    logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]         eng_count;
    dcf_pkg::dcf_ctrl_t ctrl_fields;
    dcf_pkg::dcf_addr_t item_addr;
    int                 err_count, tests_run;
    logic [5:0]         tbl [5] = '{6'h0C, 6'h19, 6'h25, 6'h30, 6'h2A}; // dst step, src step, width
    dcf_channel DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .item_done(item_done), .ctrl_fields(ctrl_fields),
        .item_addr(item_addr), .config_error(config_error));
    dcf_engine_model u_eng (.aclk(aclk), .aresetn(aresetn), .go(eng_go), .count(eng_count),
        .gap(eng_gap), .item_done(item_done), .busy(eng_busy));
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write one word; each handshake is judged on the values standing at a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic tb;
        tb = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!tb)
        begin
            @(posedge aclk);
            tb = s_axi_bvalid && s_axi_bready;
            rs = s_axi_bresp;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    // Read one word into rd and rs
    task automatic rdr(input logic [11:0] a);
        logic tr;
        tr = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!tr)
        begin
            @(posedge aclk);
            tr = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    // Four-item transfer with the given step codes and equal widths
    task automatic run(input logic [1:0] cd, input logic [1:0] cs, input logic [1:0] w);
        logic [31:0] ud, us, ctl;
        ud  = (cd == 2'h3) ? 32'h0 : (32'h1 << cd);
        us  = (cs == 2'h3) ? 32'h0 : (32'h1 << cs);
        ctl = {cd, w, cs, w, 6'h2A, 18'h0};
        wr(`DCF_OFS_SRC_END, 32'h0000_1003);
        wr(`DCF_OFS_DST_END, 32'h4000_0207);
        wr(`DCF_OFS_CTRL, ctl);
        chk({24'h0, ctrl_fields.dst_step, ctrl_fields.dst_width, ctrl_fields.src_step,
             ctrl_fields.src_width}, {24'h0, cd, w, cs, w});
        rdr(`DCF_OFS_CTRL);
        chk(rd, ctl);
        chk({30'h0, rs}, {30'h0, `DCF_RESP_OKAY});
        wr(`DCF_OFS_START, 32'h0000_0003);
        chk({30'h0, rs}, {30'h0, `DCF_RESP_OKAY});
        rdr(`DCF_OFS_STATUS);
        chk(rd & 32'h0003_FC03, 32'h0000_0C01);
        chk({31'h0, config_error}, 32'h0);
        rdr(`DCF_OFS_DST_ADDR);
        chk(rd, 32'h4000_0207 - 3 * ud);
        rdr(`DCF_OFS_SRC_ADDR);
        chk(rd, 32'h0000_1003 - 3 * us);
        eng_count <= 8'h03;
        eng_gap   <= {2'h0, cd};
        eng_go    <= 1'b1;
        @(posedge aclk);
        eng_go <= 1'b0;
        repeat (2) @(posedge aclk);
        while (eng_busy) @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk(item_addr.dst, 32'h4000_0207 + ud);
        chk(item_addr.src, 32'h0000_1003 + us);
        rdr(`DCF_OFS_STATUS);
        chk({31'h0, rd[0]}, 32'h0);
    endtask
    // Reserved width by read-modify-write, then start
    task automatic bad(input logic [31:0] clr, input logic [31:0] set);
        rdr(`DCF_OFS_CTRL);
        wr(`DCF_OFS_CTRL, (rd & ~clr) | set);
        wr(`DCF_OFS_START, 32'h0000_0003);
        chk({31'h0, config_error}, 32'h1);
        rdr(`DCF_OFS_STATUS);
        chk({30'h0, rd[1:0]}, 32'h2);
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, eng_count, eng_gap, eng_go} = 69'h0;
        s_axi_wstrb = 4'hF;
        err_count   = 0;
        tests_run   = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`DCF_OFS_CTRL);
        chk(rd, `DCF_RESET_WORD);
        wr(12'h100, 32'hA5A5_A5A5);
        chk({30'h0, rs}, {30'h0, `DCF_RESP_SLVERR});
        rdr(12'h100);
        chk({rd[29:0], rs}, {30'h0, `DCF_RESP_SLVERR});
        // Single byte lane write leaves the other lanes at their old value
        s_axi_wstrb <= 4'h1;
        wr(`DCF_OFS_DST_END, 32'hFFFF_FF5A);
        s_axi_wstrb <= 4'hF;
        rdr(`DCF_OFS_DST_END);
        chk(rd, 32'h0000_005A);
        for (int i = 0; i < 5; i++)
            run(tbl[i][5:4], tbl[i][3:2], tbl[i][1:0]);
        bad(32'h0, 32'h3000_0000);
        bad(32'h3000_0000, 32'h0300_0000);
        run(2'h0, 2'h0, 2'h0);
        test_done;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_count++;
        test_done;
    end
endmodule
bind dcf_channel dcf_channel_props u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .item_done, .ctrl_fields, .item_addr, .config_error);
